// ===== core/asgp_top.sv
// three analog-shared gpio ports with their register decode and pin muxing
// How it works
// - direction bit one makes the pin an input, driver off, unless a second-port peripheral owns the pin.
// - direction bit zero drives the pin from its latch bit unless the pin is analog or peripheral-owned.
// - data reads return pin levels, zero on analog pins; writes only change the output latch.
// - all eight first-port pins can be digital or converter inputs.
// - after reset first-port pins are analog until configuration says digital.
// - first-port bits 0 to 7 are channels 4 to 11 ascending.
// - second-port low nibble shares channels; bit 0 is channel 3, descending.
// - second-port bits 2 and 3 may serve as low and high reference.
// - second-port bits 4 to 7: capture, pulse output, serial receive, transmit.
// - after reset second-port low nibble is analog until made digital.
// - third-port upper nibble shares channels; lower nibble is plain digital.
// - third-port bits 4 to 7 are channels 12 to 15 ascending.
// - after reset third-port upper nibble is analog until made digital.
`timescale 1ns/1ps
module asgp_top
	import asgp_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire asgp_req_t         req,
	output logic      [PORT_W-1:0] rdata,
	output logic                   rd_ack,
	input  wire logic [PORT_W-1:0] first_port_pin_in,
	output logic      [PORT_W-1:0] first_port_pin_out,
	output logic      [PORT_W-1:0] first_port_pin_oe_n,
	input  wire logic [PORT_W-1:0] second_port_pin_in,
	output logic      [PORT_W-1:0] second_port_pin_out,
	output logic      [PORT_W-1:0] second_port_pin_oe_n,
	input  wire logic [PORT_W-1:0] third_port_pin_in,
	output logic      [PORT_W-1:0] third_port_pin_out,
	output logic      [PORT_W-1:0] third_port_pin_oe_n,
	output logic      [NUM_CH-1:0] channel_analog,
	output logic                   ref_low_external,
	output logic                   ref_high_external,
	output logic      [1:0]        conv_clock_sel,
	output logic                   result_format,
	input  wire logic              pulse_three_on,
	input  wire logic              pulse_output_three,
	input  wire logic              serial_two_on,
	input  wire logic              serial_two_rx_drive,
	input  wire logic              serial_two_rx_oe_n,
	input  wire logic              serial_two_tx_drive,
	input  wire logic              serial_two_tx_oe_n,
	output logic                   capture_input_three,
	output logic                   serial_two_receive_data,
	output logic                   serial_two_transmit_clock
);

	// bank and offset decode
	logic in_bank_fg;
	logic in_bank_h;
	logic in_bank_cfg;
	logic hit_f_dir;
	logic hit_f_data;
	logic hit_g_dir;
	logic hit_g_data;
	logic hit_h_dir;
	logic hit_h_data;
	logic hit_cfg;

	// first and second port only in bank 5
	assign in_bank_fg  = (req.bank == BANK_FG);
	assign in_bank_h   = (req.bank == BANK_H);
	assign in_bank_cfg = (req.bank == BANK_CFG);

	// address passed in: a continuous assign does not watch what a function reads itself
	function automatic logic reg_hit(
		input logic              bank_ok,
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs
	);
		return bank_ok && (addr == ofs);
	endfunction

	assign hit_f_dir  = reg_hit(in_bank_fg, req.addr, OFS_F_DIR);
	assign hit_f_data = reg_hit(in_bank_fg, req.addr, OFS_F_DATA);
	assign hit_g_dir  = reg_hit(in_bank_fg, req.addr, OFS_G_DIR);
	assign hit_g_data = reg_hit(in_bank_fg, req.addr, OFS_G_DATA);
	assign hit_h_dir  = reg_hit(in_bank_h, req.addr, OFS_H_DIR);
	assign hit_h_data = reg_hit(in_bank_h, req.addr, OFS_H_DATA);
	assign hit_cfg    = reg_hit(in_bank_cfg, req.addr, OFS_CFG);

	// write strobes, one per register
	logic we_f_dir;
	logic we_f_data;
	logic we_g_dir;
	logic we_g_data;
	logic we_h_dir;
	logic we_h_data;
	logic we_cfg;

	// a wrong-bank or unmapped write matches no strobe and is dropped
	assign we_f_dir  = req.wr && hit_f_dir;
	assign we_f_data = req.wr && hit_f_data;
	assign we_g_dir  = req.wr && hit_g_dir;
	assign we_g_data = req.wr && hit_g_data;
	assign we_h_dir  = req.wr && hit_h_dir;
	assign we_h_data = req.wr && hit_h_data;
	assign we_cfg    = req.wr && hit_cfg;

	// configuration register and channel decode
	logic [PORT_W-1:0] cfg;
	logic [NUM_CH-1:0] ch_analog;

	asgp_cfg u_cfg (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.we        (we_cfg),
		.wdata     (req.wdata),
		.cfg       (cfg),
		.ch_analog (ch_analog)
	);

	// channel order to pin order
	logic [PORT_W-1:0] f_analog;
	logic [PORT_W-1:0] g_analog;
	logic [PORT_W-1:0] h_analog;

	always_comb begin
		f_analog = '0;
		g_analog = '0;
		h_analog = '0;
		for (int i = 0; i < PORT_W; i++) begin
			f_analog[i] = ch_analog[F_CH_BASE + i];
		end
		for (int i = 0; i < G_SHARED; i++) begin
			g_analog[i] = ch_analog[G_CH_TOP - i];
		end
		for (int i = 0; i < PORT_W - H_SHARED_LO; i++) begin
			h_analog[H_SHARED_LO + i] = ch_analog[H_CH_BASE + i];
		end
	end

	// second-port peripheral overrides
	asgp_periph_t none_periph;
	asgp_periph_t g_periph;

	assign none_periph = '0;

	always_comb begin
		g_periph = '0;
		g_periph.take[G_PWM_BIT] = pulse_three_on;
		g_periph.out[G_PWM_BIT]  = pulse_output_three;
		g_periph.oe_n[G_PWM_BIT] = 1'b0;
		g_periph.take[G_RX_BIT]  = serial_two_on;
		g_periph.out[G_RX_BIT]   = serial_two_rx_drive;
		g_periph.oe_n[G_RX_BIT]  = serial_two_rx_oe_n;
		g_periph.take[G_TX_BIT]  = serial_two_on;
		g_periph.out[G_TX_BIT]   = serial_two_tx_drive;
		g_periph.oe_n[G_TX_BIT]  = serial_two_tx_oe_n;
	end

	// the three ports
	logic [PORT_W-1:0] f_dir;
	logic [PORT_W-1:0] f_latch;
	logic [PORT_W-1:0] f_rd;
	logic [PORT_W-1:0] g_dir;
	logic [PORT_W-1:0] g_latch;
	logic [PORT_W-1:0] g_rd;
	logic [PORT_W-1:0] h_dir;
	logic [PORT_W-1:0] h_latch;
	logic [PORT_W-1:0] h_rd;

	asgp_port #(
		.W         (PORT_W),
		.LATCH_RST (F_LATCH_RST)
	) u_first (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.dir_we   (we_f_dir),
		.data_we  (we_f_data),
		.wdata    (req.wdata),
		.analog   (f_analog),
		.periph   (none_periph),
		.pin_in   (first_port_pin_in),
		.dir      (f_dir),
		.latch    (f_latch),
		.rd_value (f_rd),
		.pin_out  (first_port_pin_out),
		.pin_oe_n (first_port_pin_oe_n)
	);

	asgp_port #(
		.W         (PORT_W),
		.LATCH_RST (G_LATCH_RST)
	) u_second (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.dir_we   (we_g_dir),
		.data_we  (we_g_data),
		.wdata    (req.wdata),
		.analog   (g_analog),
		.periph   (g_periph),
		.pin_in   (second_port_pin_in),
		.dir      (g_dir),
		.latch    (g_latch),
		.rd_value (g_rd),
		.pin_out  (second_port_pin_out),
		.pin_oe_n (second_port_pin_oe_n)
	);

	asgp_port #(
		.W         (PORT_W),
		.LATCH_RST (H_LATCH_RST)
	) u_third (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.dir_we   (we_h_dir),
		.data_we  (we_h_data),
		.wdata    (req.wdata),
		.analog   (h_analog),
		.periph   (none_periph),
		.pin_in   (third_port_pin_in),
		.dir      (h_dir),
		.latch    (h_latch),
		.rd_value (h_rd),
		.pin_out  (third_port_pin_out),
		.pin_oe_n (third_port_pin_oe_n)
	);

	// read selection; unmapped addresses read zero
	logic [PORT_W-1:0] next_rdata;

	assign next_rdata = ({PORT_W{hit_f_dir}}  & f_dir)
	                  | ({PORT_W{hit_f_data}} & f_rd)
	                  | ({PORT_W{hit_g_dir}}  & g_dir)
	                  | ({PORT_W{hit_g_data}} & g_rd)
	                  | ({PORT_W{hit_h_dir}}  & h_dir)
	                  | ({PORT_W{hit_h_data}} & h_rd)
	                  | ({PORT_W{hit_cfg}}    & cfg);

	// converter-facing values
	logic next_ref_low;
	logic next_ref_high;

	// a reference pin turned digital cannot carry a reference
	function automatic logic ref_external(input logic [PORT_W-1:0] c, input logic ch_is_analog);
		return c[CFG_PCFG_HI] & ch_is_analog;
	endfunction

	assign next_ref_low  = ref_external(cfg, ch_analog[CH_REF_LOW]);
	assign next_ref_high = ref_external(cfg, ch_analog[CH_REF_HIGH]);

	// peripheral inputs see the pin unless it is analog-blocked
	logic next_capture;
	logic next_rx;
	logic next_tx;

	assign next_capture = g_rd[G_CAP_BIT];
	assign next_rx      = g_rd[G_RX_BIT];
	assign next_tx      = g_rd[G_TX_BIT];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata  <= '0;
			rd_ack <= 1'b0;
		end else begin
			rdata  <= req.rd ? next_rdata : '0;
			rd_ack <= req.rd;
		end
	end

	// registered so every output leaves a flip-flop
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			channel_analog    <= '1;
			ref_low_external  <= 1'b0;
			ref_high_external <= 1'b0;
			conv_clock_sel    <= '0;
			result_format     <= 1'b0;
		end else begin
			channel_analog    <= ch_analog;
			ref_low_external  <= next_ref_low;
			ref_high_external <= next_ref_high;
			conv_clock_sel    <= cfg[CFG_CLK_HI:CFG_CLK_LO];
			result_format     <= cfg[CFG_FMT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			capture_input_three       <= 1'b0;
			serial_two_receive_data   <= 1'b0;
			serial_two_transmit_clock <= 1'b0;
		end else begin
			capture_input_three       <= next_capture;
			serial_two_receive_data   <= next_rx;
			serial_two_transmit_clock <= next_tx;
		end
	end

endmodule

// ===== core/asgp_pkg.sv
// shared constants and carrier types for the analog-shared gpio ports
package asgp_pkg;

	localparam int unsigned PORT_W = 8;
	localparam int unsigned BANK_W = 4;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned NUM_CH = 16;
	localparam int unsigned CH_W   = 5;

	// bank in which each register is decoded
	localparam logic [BANK_W-1:0] BANK_FG  = 4'h5;
	localparam logic [BANK_W-1:0] BANK_H   = 4'h8;
	localparam logic [BANK_W-1:0] BANK_CFG = 4'h5;

	// register offsets within their bank
	localparam logic [ADDR_W-1:0] OFS_F_DIR  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_F_DATA = 8'h11;
	localparam logic [ADDR_W-1:0] OFS_G_DIR  = 8'h12;
	localparam logic [ADDR_W-1:0] OFS_G_DATA = 8'h13;
	localparam logic [ADDR_W-1:0] OFS_CFG    = 8'h15;
	localparam logic [ADDR_W-1:0] OFS_H_DIR  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_H_DATA = 8'h11;

	// reset values
	localparam logic [PORT_W-1:0] DIR_RST     = 8'hff;
	localparam logic [PORT_W-1:0] F_LATCH_RST = 8'h00;
	localparam logic [PORT_W-1:0] G_LATCH_RST = 8'h00;
	localparam logic [PORT_W-1:0] H_LATCH_RST = 8'h00;
	localparam logic [PORT_W-1:0] CFG_RST     = 8'h00;

	// converter_pin_config fields; bit 4 is unimplemented
	localparam int unsigned      CFG_CLK_HI   = 7;
	localparam int unsigned      CFG_CLK_LO   = 6;
	localparam int unsigned      CFG_FMT      = 5;
	localparam int unsigned      CFG_PCFG_HI  = 3;
	localparam int unsigned      CFG_PCFG_LO  = 0;
	localparam logic [PORT_W-1:0] CFG_IMPL    = 8'hef;
	localparam logic [3:0]       PCFG_DIGITAL = 4'he;
	localparam logic [CH_W-1:0]  CH_ALL       = 5'h10;

	// converter channel placement
	localparam int unsigned F_CH_BASE   = 4;
	localparam int unsigned G_CH_TOP    = 3;
	localparam int unsigned G_SHARED    = 4;
	localparam int unsigned H_SHARED_LO = 4;
	localparam int unsigned H_CH_BASE   = 12;
	localparam int unsigned CH_REF_LOW  = 1;
	localparam int unsigned CH_REF_HIGH = 0;

	// second port alternate functions
	localparam int unsigned G_CAP_BIT = 4;
	localparam int unsigned G_PWM_BIT = 5;
	localparam int unsigned G_RX_BIT  = 6;
	localparam int unsigned G_TX_BIT  = 7;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic [PORT_W-1:0] wdata;
	} asgp_req_t;

	typedef struct packed {
		logic [PORT_W-1:0] take;
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oe_n;
	} asgp_periph_t;

endpackage

// ===== core/asgp_port.sv
// one 8-bit bidirectional port: direction, output latch, pin drive, read path
`timescale 1ns/1ps
module asgp_port
	import asgp_pkg::*;
#(
	parameter int unsigned        W         = PORT_W,
	parameter logic [PORT_W-1:0]  LATCH_RST = 8'h00
) (
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire logic            dir_we,
	input  wire logic            data_we,
	input  wire logic [W-1:0]    wdata,
	input  wire logic [W-1:0]    analog,
	input  wire asgp_periph_t    periph,
	input  wire logic [W-1:0]    pin_in,
	output logic      [W-1:0]    dir,
	output logic      [W-1:0]    latch,
	output logic      [W-1:0]    rd_value,
	output logic      [W-1:0]    pin_out,
	output logic      [W-1:0]    pin_oe_n
);

	logic [W-1:0] next_out;
	logic [W-1:0] next_oe_n;

	assign next_out  = (periph.take[W-1:0] & periph.out[W-1:0]) | (~periph.take[W-1:0] & latch);
	assign next_oe_n = analog | (periph.take[W-1:0] & periph.oe_n[W-1:0]) | (~periph.take[W-1:0] & dir);
	assign rd_value  = pin_in & ~analog;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dir      <= DIR_RST[W-1:0];
			latch    <= LATCH_RST[W-1:0];
			pin_out  <= '0;
			pin_oe_n <= '1;
		end else begin
			if (data_we) begin
				latch <= wdata;
			end
			if (dir_we) begin
				dir <= wdata;
			end
			pin_out  <= next_out;
			pin_oe_n <= next_oe_n;
		end
	end

endmodule

// ===== core/asgp_cfg.sv
// converter pin configuration register and analog channel decode
`timescale 1ns/1ps
module asgp_cfg
	import asgp_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              we,
	input  wire logic [PORT_W-1:0] wdata,
	output logic      [PORT_W-1:0] cfg,
	output logic      [NUM_CH-1:0] ch_analog
);

	logic [3:0]      pin_config;
	logic [CH_W-1:0] count;

	// channels below the count are analog; top codes leave none
	function automatic logic [CH_W-1:0] analog_count(input logic [3:0] p);
		if (p >= PCFG_DIGITAL) begin
			return '0;
		end
		return CH_ALL - {1'b0, p};
	endfunction

	assign pin_config = cfg[CFG_PCFG_HI:CFG_PCFG_LO];
	assign count      = analog_count(pin_config);

	always_comb begin
		ch_analog = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			ch_analog[i] = (CH_W'(i) < count);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg <= CFG_RST;
		end else if (we) begin
			cfg <= wdata & CFG_IMPL;
		end
	end

endmodule

// ===== testbench/asgp_chk.sv
// port-level assertions for the gpio block
`timescale 1ns/1ps
module asgp_chk
	import asgp_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst,
	input wire asgp_req_t         req,
	input wire logic [PORT_W-1:0] rdata,
	input wire logic              rd_ack,
	input wire logic [PORT_W-1:0] first_port_pin_oe_n,
	input wire logic [PORT_W-1:0] second_port_pin_in,
	input wire logic [PORT_W-1:0] second_port_pin_out,
	input wire logic [PORT_W-1:0] second_port_pin_oe_n,
	input wire logic [PORT_W-1:0] third_port_pin_in,
	input wire logic [NUM_CH-1:0] channel_analog,
	input wire logic              pulse_three_on,
	input wire logic              pulse_output_three,
	input wire logic              serial_two_on,
	input wire logic              serial_two_tx_drive,
	input wire logic              serial_two_tx_oe_n,
	input wire logic              capture_input_three,
	input wire logic              serial_two_receive_data
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_rd_h;
		req.rd && req.bank == BANK_H && req.addr == OFS_H_DATA;
	endsequence
	// analog view may lag config by one edge
	sequence s_f_analog;
		channel_analog[11:4] == 8'hff ##1 channel_analog[11:4] == 8'hff;
	endsequence

	property p_ack; req.rd |=> rd_ack; endproperty
	property p_idle; !req.rd |=> !rd_ack && rdata == 8'h00; endproperty
	property p_rst;
		disable iff (1'b0) rst |=> channel_analog == 16'hffff && first_port_pin_oe_n == 8'hff && !rd_ack;
	endproperty
	property p_f_analog; s_f_analog |-> first_port_pin_oe_n == 8'hff; endproperty
	property p_unmapped;
		req.rd && req.bank != BANK_FG && req.bank != BANK_H |=> rd_ack && rdata == 8'h00;
	endproperty
	property p_h_low; s_rd_h |=> rdata[3:0] == $past(third_port_pin_in[3:0]); endproperty
	property p_pwm;
		pulse_three_on |=> !second_port_pin_oe_n[5] && second_port_pin_out[5] == $past(pulse_output_three);
	endproperty
	property p_tx;
		serial_two_on |=> second_port_pin_out[7] == $past(serial_two_tx_drive)
			&& second_port_pin_oe_n[7] == $past(serial_two_tx_oe_n);
	endproperty
	property p_cap;
		1'b1 |=> capture_input_three == $past(second_port_pin_in[4])
			&& serial_two_receive_data == $past(second_port_pin_in[6]);
	endproperty

	a_ack: assert property (p_ack) else $error("read not acknowledged");
	a_idle: assert property (p_idle) else $error("stray read answer");
	a_rst: assert property (p_rst) else $error("reset state wrong");
	a_f_analog: assert property (p_f_analog) else $error("analog pin driven");
	a_unmapped: assert property (p_unmapped) else $error("wrong bank answered");
	a_h_low: assert property (p_h_low) else $error("low nibble not pin level");
	a_pwm: assert property (p_pwm) else $error("pulse output not on pin");
	a_tx: assert property (p_tx) else $error("serial transmit not on pin");
	a_cap: assert property (p_cap) else $error("capture or receive wrong");
endmodule

bind asgp_top asgp_chk chk_u (
	.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .rd_ack(rd_ack),
	.first_port_pin_oe_n(first_port_pin_oe_n), .second_port_pin_in(second_port_pin_in),
	.second_port_pin_out(second_port_pin_out), .second_port_pin_oe_n(second_port_pin_oe_n),
	.third_port_pin_in(third_port_pin_in), .channel_analog(channel_analog),
	.pulse_three_on(pulse_three_on), .pulse_output_three(pulse_output_three),
	.serial_two_on(serial_two_on), .serial_two_tx_drive(serial_two_tx_drive),
	.serial_two_tx_oe_n(serial_two_tx_oe_n), .capture_input_three(capture_input_three),
	.serial_two_receive_data(serial_two_receive_data)
);

// ===== testbench/asgp_pins.sv
// external pin model: resolves one port's pin levels
`timescale 1ns/1ps
module asgp_pins
	import asgp_pkg::*;
(
	input  wire logic [PORT_W-1:0] out,
	input  wire logic [PORT_W-1:0] oe_n,
	input  wire logic [PORT_W-1:0] ext,
	output logic      [PORT_W-1:0] level
);
	assign level = (oe_n & ext) | (~oe_n & out);
endmodule

// ===== testbench/asgp_top_tb.sv
// self-checking bench for the analog-shared gpio ports
`timescale 1ns/1ps
module asgp_top_tb;
	import asgp_pkg::*;
	logic ref_clk, rst, p3_on, p3_val, s2_on, rx_d, rx_oe, tx_d, tx_oe, cap, rxd, txc, rlo, rhi, fmt;
	asgp_req_t req;
	logic [1:0] csel;
	logic [7:0] rdata, f_out, f_oe, f_in, f_ext, g_out, g_oe, g_in, g_ext, h_out, h_oe, h_in, h_ext;
	logic rd_ack;
	logic [15:0] ch;
	int fails, cmp_count;

	asgp_top dut_u (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .rd_ack(rd_ack),
		.first_port_pin_in(f_in), .first_port_pin_out(f_out), .first_port_pin_oe_n(f_oe),
		.second_port_pin_in(g_in), .second_port_pin_out(g_out), .second_port_pin_oe_n(g_oe),
		.third_port_pin_in(h_in), .third_port_pin_out(h_out), .third_port_pin_oe_n(h_oe),
		.channel_analog(ch), .ref_low_external(rlo), .ref_high_external(rhi),
		.conv_clock_sel(csel), .result_format(fmt), .pulse_three_on(p3_on),
		.pulse_output_three(p3_val), .serial_two_on(s2_on), .serial_two_rx_drive(rx_d),
		.serial_two_rx_oe_n(rx_oe), .serial_two_tx_drive(tx_d), .serial_two_tx_oe_n(tx_oe),
		.capture_input_three(cap), .serial_two_receive_data(rxd), .serial_two_transmit_clock(txc));
	asgp_pins f_u (.out(f_out), .oe_n(f_oe), .ext(f_ext), .level(f_in));
	asgp_pins g_u (.out(g_out), .oe_n(g_oe), .ext(g_ext), .level(g_in));
	asgp_pins h_u (.out(h_out), .oe_n(h_oe), .ext(h_ext), .level(h_in));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{1'b1, 1'b0, b, a, d};
		@(posedge ref_clk);
		req <= '0;
	endtask
	task automatic rd(input logic [3:0] b, input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		req <= '{1'b0, 1'b1, b, a, 8'h00};
		@(posedge ref_clk);
		req <= '0;
		#1;
		chk({7'h00, rd_ack, rdata}, {8'h01, e});
	endtask
	// count of analog channels is 16 minus the field, none for 0xe and 0xf
	function automatic logic [15:0] amask(input logic [3:0] p);
		amask = (p < 4'he) ? (16'hffff >> p) : 16'h0000;
	endfunction

	task automatic t_reset();
		chk(ch, 16'hffff);
		chk({f_oe, h_oe}, 16'hffff);
		rd(BANK_FG, OFS_F_DIR, DIR_RST);
		rd(BANK_FG, OFS_G_DIR, DIR_RST);
		rd(BANK_H, OFS_H_DIR, DIR_RST);
		rd(BANK_FG, OFS_CFG, CFG_RST);
		rd(BANK_FG, OFS_F_DATA, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_map();
		logic [15:0] m;
		wr(BANK_FG, OFS_F_DIR, 8'h00);
		wr(BANK_FG, OFS_G_DIR, 8'h00);
		wr(BANK_H, OFS_H_DIR, 8'h00);
		wr(BANK_FG, OFS_F_DATA, 8'hff);
		wr(BANK_FG, OFS_G_DATA, 8'hff);
		wr(BANK_H, OFS_H_DATA, 8'hff);
		for (int p = 0; p < 16; p++) begin
			m = amask(p[3:0]);
			wr(BANK_FG, OFS_CFG, {4'h0, p[3:0]});
			idle(3);
			chk(ch, m);
			chk({f_oe, h_oe}, {m[11:4], m[15:12], 4'h0});
			chk({8'h00, g_oe}, {12'h000, m[0], m[1], m[2], m[3]});
			chk({14'h0000, rlo, rhi}, {14'h0000, {2{p[3] && p < 14}}});
			rd(BANK_FG, OFS_F_DATA, ~m[11:4]);
			rd(BANK_FG, OFS_G_DATA, {4'hf, ~m[0], ~m[1], ~m[2], ~m[3]});
			rd(BANK_H, OFS_H_DATA, {~m[15:12], 4'hf});
		end
		wr(BANK_FG, OFS_CFG, 8'hff);
		idle(2);
		rd(BANK_FG, OFS_CFG, CFG_IMPL);
		chk({13'h0000, csel, fmt}, 16'h0007);
		$display("test map done");
	endtask

	task automatic t_io();
		@(posedge ref_clk);
		f_ext <= 8'h5a;
		h_ext <= 8'ha5;
		wr(BANK_FG, OFS_F_DIR, 8'h0f);
		wr(BANK_FG, OFS_F_DATA, 8'h33);
		wr(BANK_H, OFS_H_DIR, 8'hf0);
		wr(BANK_H, OFS_H_DATA, 8'h3c);
		idle(2);
		chk({f_oe, f_out}, {8'h0f, 8'h33});
		rd(BANK_FG, OFS_F_DATA, 8'h3a);
		rd(BANK_H, OFS_H_DATA, 8'hac);
		wr(4'h4, OFS_F_DIR, 8'hff);
		rd(BANK_FG, OFS_F_DIR, 8'h0f);
		rd(4'h4, OFS_F_DATA, 8'h00);
		rd(BANK_FG, 8'h14, 8'h00);
		$display("test io done");
	endtask

	task automatic t_periph();
		@(posedge ref_clk);
		g_ext <= 8'h50;
		p3_on <= 1'b1;
		p3_val <= 1'b1;
		s2_on <= 1'b1;
		tx_d <= 1'b1;
		tx_oe <= 1'b0;
		rx_oe <= 1'b1;
		wr(BANK_FG, OFS_G_DIR, 8'hff);
		idle(2);
		chk({8'h00, g_out[7], g_out[5], g_oe[7:5], cap, rxd, txc}, 16'h00d7);
		@(posedge ref_clk);
		p3_val <= 1'b0;
		rx_d <= 1'b1;
		idle(2);
		chk({14'h0000, g_out[6], g_out[5]}, 16'h0002);
		@(posedge ref_clk);
		p3_on <= 1'b0;
		s2_on <= 1'b0;
		idle(2);
		$display("test periph done");
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		req = '0;
		{p3_on, p3_val, s2_on, rx_d, rx_oe, tx_d, tx_oe} = 7'h00;
		f_ext = 8'hff;
		g_ext = 8'hff;
		h_ext = 8'hff;
		fails = 0;
		cmp_count = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		idle(1);
		t_reset();
		t_map();
		t_io();
		t_periph();
		end_of_test();
	end
endmodule
